// ===== tb/rtk_core_sva.sv
// checker for the timekeeping core: read handshake, read-only bits, running flag
// assumes it is bound to rtk_core and sees only the ports of that module
`timescale 1ns/10ps
`default_nettype none
module rtk_core_sva
    import rtk_pkg::*;
#(
    parameter int unsigned OSF_TIMEOUT_CYC = 50000
)
(
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        ce,
    input wire logic        osc_pin,
    input wire rtk_req_t    reg_req,
    input wire logic [7:0]  rd_data,
    input wire logic        rd_valid_ff,
    input wire logic        osc_running_ff
);
    logic        osc_q_ff;
    logic [15:0] idle_ff;
    logic        rd_req;
    logic        rd_go;

    assign rd_req = ce && (reg_req.rd_start || reg_req.rd_next);
    assign rd_go  = ce && reg_req.rd_start;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst)
            osc_q_ff <= 1'b0;
        else if (ce)
            osc_q_ff <= osc_pin;
    end

    // clocks since the last raw pin rise; saturates so a long stop cannot wrap
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst)
            idle_ff <= 16'h0000;
        else if (ce && osc_pin && !osc_q_ff)
            idle_ff <= 16'h0000;
        else if (ce && idle_ff != 16'hffff)
            idle_ff <= idle_ff + 16'h0001;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    read_answer_a: assert property (rd_req |=> rd_valid_ff)
        else $error("read request got no valid pulse");
    valid_cause_a: assert property (rd_valid_ff |-> $past(rd_req))
        else $error("valid pulse without a read request");
    data_hold_a: assert property (!rd_valid_ff |-> $stable(rd_data))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (rd_go && reg_req.addr > 5'h07 |=> rd_data == 8'h00)
        else $error("unmapped address read nonzero");
    sec_bcd_a: assert property (rd_go && reg_req.addr == 5'h00 |=>
        rd_data[6:4] <= 3'h5 && rd_data[3:0] <= 4'h9)
        else $error("seconds byte not bcd");
    min_top_a: assert property (rd_go && reg_req.addr == 5'h01 |=>
        !rd_data[7] && rd_data[6:4] <= 3'h5)
        else $error("minutes byte malformed");
    day_of_week_value_fixed_a: assert property (rd_go && reg_req.addr == 5'h03 |=>
        rd_data[7:6] == 2'b00 && !rd_data[4])
        else $error("weekday byte fixed bits set");
    run_set_a: assert property ($rose(osc_running_ff) |-> idle_ff <= 16'h0006)
        else $error("running flag rose without a recent edge");
    run_fall_a: assert property ($fell(osc_running_ff) |-> idle_ff >= OSF_TIMEOUT_CYC)
        else $error("running flag fell before the timeout");
    run_clear_a: assert property (idle_ff >= OSF_TIMEOUT_CYC + 8 |-> !osc_running_ff)
        else $error("running flag kept past the timeout");

    cover property (rd_req ##1 rd_req);
    cover property ($rose(osc_running_ff));
    cover property ($fell(osc_running_ff));
endmodule : rtk_core_sva

bind rtk_core rtk_core_sva #(.OSF_TIMEOUT_CYC(OSF_TIMEOUT_CYC)) rtk_core_sva_inst (
    .clock(clock), .sys_rst(sys_rst), .ce(ce), .osc_pin(osc_pin), .reg_req(reg_req),
    .rd_data(rd_data), .rd_valid_ff(rd_valid_ff), .osc_running_ff(osc_running_ff)
);
`default_nettype wire

// ===== tb/rtk_core_test.sv
// self-checking bench: reset values, register access, snapshot reads, running flag
// assumes rtk_core, rtk_osc_src and the bound checker are compiled with it
`timescale 1ns/10ps
`default_nettype none
module rtk_core_test
    import rtk_pkg::*;
;
    localparam int unsigned OSF = 64;
    localparam int LIMIT = 20000;
    logic        clock;
    logic        sys_rst;
    logic        ce;
    logic        osc_run;
    logic        osc_pin;
    logic [15:0] n_rise;
    rtk_req_t    reg_req;
    logic [7:0]  rd_data;
    logic        rd_valid_ff;
    logic        osc_running_ff;
    rtk_byte_t   got;
    int          n_fail = 0;
    int          checks = 0;
    int          cyc_cnt = 0;

    rtk_core #(.OSF_TIMEOUT_CYC(OSF)) rtk_core_inst (
        .clock(clock), .sys_rst(sys_rst), .ce(ce), .osc_pin(osc_pin), .reg_req(reg_req),
        .rd_data(rd_data), .rd_valid_ff(rd_valid_ff), .osc_running_ff(osc_running_ff)
    );
    rtk_osc_src rtk_osc_src_inst (.run(osc_run), .osc_pin(osc_pin), .n_rise(n_rise));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one register-port cycle; the valid pulse must follow exactly when ce took it
    task automatic cyc(input logic s, input logic n, input logic w, input logic [4:0] a,
                       input logic [7:0] d);
        reg_req = '{addr: a, wdata: d, wr: w, rd_start: s, rd_next: n};
        @(negedge clock);
        got = rd_data;
        if (s || n) chk("rd_valid", {7'h00, rd_valid_ff}, {7'h00, ce});
    endtask : cyc

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        cyc(1'b0, 1'b0, 1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [4:0] a);
        cyc(1'b1, 1'b0, 1'b0, a, 8'h00);
    endtask : rd

    task automatic idle();
        cyc(1'b0, 1'b0, 1'b0, 5'h00, 8'h00);
    endtask : idle

    task automatic flag_is(input logic v);
        chk("run_flag", {7'h00, osc_running_ff}, {7'h00, v});
    endtask : flag_is

    task automatic wait_rise(input int k);
        int base;
        int t;
        base = n_rise;
        t = 0;
        while (int'(n_rise) - base < k && t < 16 * k) begin
            @(negedge clock);
            t++;
        end
    endtask : wait_rise

    task automatic burst(input logic [7:0] e [8]);
        for (int i = 0; i < 8; i++) begin
            cyc(i == 0, i != 0, 1'b0, 5'h00, 8'h00);
            chk("burst_byte", got, e[i]);
        end
        idle();
    endtask : burst

    task automatic t_reset();
        flag_is(1'b0);
        burst('{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h21, 8'h00, 8'h00});
    endtask : t_reset

    task automatic t_regs();
        wr(5'h01, 8'h59);
        wr(5'h02, 8'h72);
        wr(5'h03, 8'h1f);
        wr(5'h04, 8'h31);
        wr(5'h05, 8'h12);
        wr(5'h06, 8'h99);
        wr(5'h10, 8'haa);
        burst('{8'h00, 8'h59, 8'h72, 8'h0f, 8'h31, 8'h12, 8'h99, 8'h00});
        rd(5'h10);
        chk("unmapped", got, 8'h00);
        idle();
        ce = 1'b0;
        rd(5'h01);
        chk("frozen_data", got, 8'h00);
        ce = 1'b1;
        idle();
    endtask : t_regs

    task automatic t_osc();
        osc_run = 1'b1;
        wait_rise(40);
        flag_is(1'b0);
        wr(5'h00, 8'h80);
        idle();
        wait_rise(30);
        flag_is(1'b0);
        wait_rise(4);
        repeat (6) @(negedge clock);
        flag_is(1'b1);
        rd(5'h03);
        chk("day_of_week_value_status", got, 8'h2f);
        wr(5'h03, 8'h01);
        rd(5'h03);
        chk("day_of_week_value_status", got, 8'h21);
        rd(5'h00);
        chk("sec_start", got, 8'h80);
        // pin stops before the gate closes, so the checker's idle count stays honest
        osc_run = 1'b0;
        repeat (10) @(negedge clock);
        wr(5'h00, 8'h00);
        idle();
        repeat (OSF / 2) @(negedge clock);
        flag_is(1'b1);
        for (int t = 0; t < OSF + 16 && osc_running_ff !== 1'b0; t++) @(negedge clock);
        flag_is(1'b0);
        wr(5'h01, 8'h30);
        wr(5'h07, 8'h08);
        idle();
        osc_run = 1'b1;
        wait_rise(36);
        repeat (6) @(negedge clock);
        flag_is(1'b1);
        rd(5'h07);
        chk("ext_enable", got, 8'h08);
        osc_run = 1'b0;
        repeat (10) @(negedge clock);
        wr(5'h07, 8'h00);
        idle();
    endtask : t_osc

    task automatic t_snap();
        wr(5'h01, 8'h33);
        rd(5'h00);
        cyc(1'b0, 1'b1, 1'b1, 5'h01, 8'h44);
        chk("stale_min", got, 8'h33);
        rd(5'h1e);
        cyc(1'b0, 1'b1, 1'b1, 5'h01, 8'h55);
        chk("last_addr", got, 8'h00);
        cyc(1'b0, 1'b1, 1'b0, 5'h00, 8'h00);
        cyc(1'b0, 1'b1, 1'b0, 5'h00, 8'h00);
        chk("wrap_min", got, 8'h55);
        rd(5'h01);
        chk("min_direct", got, 8'h55);
        idle();
    endtask : t_snap

    task automatic close_out();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc_cnt++;
        if (cyc_cnt == LIMIT) begin
            n_fail++;
            close_out();
        end
    end

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        osc_run = 1'b0;
        reg_req = '0;
        repeat (6) @(negedge clock);
        sys_rst = 1'b0;
        t_reset();
        t_regs();
        t_osc();
        t_snap();
        close_out();
    end
endmodule : rtk_core_test
`default_nettype wire

// ===== tb/rtk_osc_src.sv
// external time-base source driving the oscillator pin of the core
// assumes the bench starts and stops it; it stands low while stopped
`timescale 1ns/10ps
`default_nettype none
module rtk_osc_src #(
    parameter real HALF_NS = 80.0
)
(
    input  wire logic   run,
    output logic        osc_pin,
    output logic [15:0] n_rise
);
    // odd start offset keeps the pin edges off the system clock edges, at a fixed phase
    initial begin
        osc_pin = 1'b0;
        n_rise = 16'h0000;
        #7;
        forever begin
            if (run) begin
                #(HALF_NS) osc_pin = 1'b1;
                n_rise = n_rise + 16'h0001;
                #(HALF_NS) osc_pin = 1'b0;
            end
            else begin
                osc_pin = 1'b0;
                #(HALF_NS);
            end
        end
    end
endmodule : rtk_osc_src
`default_nettype wire

// ===== verilog/rtk_core.sv
// timekeeping core: oscillator supervision, bcd calendar, buffered register reads
// assumes a byte-level register port from the serial engine on the same clock,
// and the crystal/external clock input arriving asynchronously on osc_pin
//
// What this block does and what it expects of the host
// (R01) set the running flag after 32 gated oscillator cycles are seen
// (R02) clear the running flag when no cycle arrives within the fail timeout
// (R03) seconds bit 7 starts the crystal oscillator when 1, stops it when 0
// (R04) count time from the 32.768 kHz crystal or external clock input
// (R05) shorten short months and correct leap years, two-digit year kept
// (R06) february ends at 29 in leap years, otherwise at 28
// (R07) date past the month maximum rolls to 01 and carries into month
// (R08) 11:59:59 pm or 23:59:59 wraps to midnight, carrying date and weekday
// (R09) weekday counts 1 to 7, steps at midnight, wraps to 1, no carry
// (R10) month wraps from 12/31 to 01/01 and carries into the year
// (R11) year wraps from 99 to 00 with no further carry
// (R12) hour format bit selects 12-hour or 24-hour counting
// (R13) all time and date fields are kept as bcd digits
// (R14) reads come from a copy refreshed when any read starts at 0x00-0x1f
// (R15) sequential reads refresh the copy when the address wraps 0x1f to 0x00
// (R16) host should read all time registers in one continuous read
// (R17) host stops the clock, waits for running clear, writes, restarts
// (R18) host writes only valid calendar values
// (R19) seconds: tens 0-5 in bits 6-4, ones in bits 3-0, reset zero
// (R20) minutes: bit 7 reads zero, tens bits 6-4, ones bits 3-0
// (R21) running flag is read-only: 1 enabled and running, 0 stopped
// (R22) 12-hour: bit 5 pm, bit 4 tens; 24-hour: bits 5-4 tens 0-2
// (R23) fail timeout is a parameter timed by the system clock
// (R24) seconds 59 carries into minutes, minutes 59 carries into hours
`timescale 1ns/10ps
`default_nettype none
`include "rtk_map.svh"

module rtk_core
    import rtk_pkg::*;
#(
    parameter int unsigned OSF_TIMEOUT_CYC = `RTK_OSF_TIMEOUT_US * `RTK_CLK_MHZ
)
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    input  wire logic       osc_pin,
    input  wire rtk_req_t   reg_req,
    output logic [7:0]      rd_data,
    output logic            rd_valid_ff,
    output logic            osc_running_ff
);

    // ---------------- bcd helpers ----------------
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (v[3:0] == 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction : bcd_inc

    // divisible by four in bcd: even tens with 0/4/8, odd tens with 2/6
    function automatic logic bcd_leap(input logic [7:0] y);
        logic l;
        l = 1'b0;
        if (!y[4]) begin
            l = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end else begin
            l = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
        return l;
    endfunction : bcd_leap

    // ---------------- state ----------------
    rtk_time_t   time_ff;
    rtk_time_t   nxt_time;
    logic        start_ff;
    logic        hr_fmt_ff;
    logic        vbat_en_ff;
    logic [7:0]  ctrl_ff;
    logic        osc_s1_ff;
    logic        osc_s2_ff;
    logic        osc_s3_ff;
    logic [5:0]  edge_cnt_ff;
    logic [31:0] idle_cnt_ff;
    logic [14:0] prescale_ff;
    logic [4:0]  rd_ptr_ff;

    logic        clk_gate;
    logic        osc_edge;
    logic        sec_tick;
    logic        osf_expired;
    logic        wr_en;
    logic        snap_load;
    logic        rd_en;
    logic [4:0]  rd_addr;
    logic [4:0]  ptr_inc;
    logic        leap;
    logic [5:0]  date_max;
    rtk_byte_t [`RTK_SNAP_DEPTH-1:0] live_bytes;

    assign wr_en = ce && reg_req.wr;
    // divisible-by-four only; a two-digit year cannot tell centuries apart
    assign leap = bcd_leap(time_ff.year);

    // ---------------- oscillator input and supervision ----------------
    // only the second and third stages feed the edge detector; the first may be metastable
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
            osc_s3_ff <= 1'b0;
        end else if (ce) begin
            osc_s1_ff <= osc_pin;
            osc_s2_ff <= osc_s1_ff;
            osc_s3_ff <= osc_s2_ff;
        end
    end

    // crystal runs on the start bit, the external input on its enable
    assign clk_gate = start_ff || ctrl_ff[`RTK_BIT_EXT_CLK]; // R03
    assign osc_edge = osc_s2_ff && !osc_s3_ff && clk_gate; // R04
    assign osf_expired = (idle_cnt_ff >= (OSF_TIMEOUT_CYC - 32'h1)) && !osc_edge;

    // idle time is measured on the system clock, independent of the oscillator
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            idle_cnt_ff <= 32'h0;
        end else if (ce) begin
            if (osc_edge) begin
                idle_cnt_ff <= 32'h0;
            end else if (!osf_expired) begin
                idle_cnt_ff <= idle_cnt_ff + 32'h1; // R23
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            edge_cnt_ff    <= 6'h0;
            osc_running_ff <= 1'b0;
        end else if (ce) begin
            if (osc_edge) begin
                if (edge_cnt_ff == `RTK_RUN_EDGES - 6'h1) begin
                    osc_running_ff <= 1'b1; // R01
                end
                if (edge_cnt_ff != `RTK_RUN_EDGES - 6'h1) begin
                    edge_cnt_ff <= edge_cnt_ff + 6'h1;
                end
            end else if (osf_expired) begin
                osc_running_ff <= 1'b0; // R02
                edge_cnt_ff    <= 6'h0;
            end
        end
    end

    // ---------------- one second time base ----------------
    // writing seconds restarts the fraction so the new second is a full one
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prescale_ff <= 15'h0;
        end else if (ce) begin
            if (wr_en && reg_req.addr == `RTK_ADDR_SEC) begin
                prescale_ff <= 15'h0;
            end else if (osc_edge) begin
                prescale_ff <= prescale_ff + 15'h1; // R04
            end
        end
    end

    assign sec_tick = osc_edge && (prescale_ff == `RTK_PRESCALE_LAST);

    // ---------------- calendar advance ----------------
    always_comb begin
        case (time_ff.mth)
            5'h02: date_max = leap ? 6'h29 : 6'h28; // R06
            5'h04,
            5'h06,
            5'h09,
            5'h11: date_max = 6'h30; // R05
            5'h01,
            5'h03,
            5'h05,
            5'h07,
            5'h08,
            5'h10,
            5'h12: date_max = 6'h31; // R07
            // an illegal month still gets a bound so the date cannot run away
            default: date_max = 6'h31;
        endcase
    end

    always_comb begin
        logic day_carry;
        logic mth_carry;
        nxt_time  = time_ff;
        day_carry = 1'b0;
        mth_carry = 1'b0;
        if (time_ff.sec == 7'h59) begin
            nxt_time.sec = 7'h00;
            if (time_ff.min == 7'h59) begin
                nxt_time.min = 7'h00; // R24
                if (hr_fmt_ff) begin
                    // 12-hour: bit 5 is pm, bits 4-0 run 01..12
                    case (time_ff.hour[4:0])
                        5'h11: begin
                            nxt_time.hour = {~time_ff.hour[5], 5'h12}; // R22
                            day_carry = time_ff.hour[5]; // R08
                        end
                        5'h12: nxt_time.hour = {time_ff.hour[5], 5'h01};
                        default: nxt_time.hour = {time_ff.hour[5],
                                                  5'(bcd_inc({3'h0, time_ff.hour[4:0]}))};
                    endcase
                end else if (time_ff.hour == 6'h23) begin
                    nxt_time.hour = 6'h00;
                    day_carry = 1'b1; // R08
                end else begin
                    nxt_time.hour = 6'(bcd_inc({2'h0, time_ff.hour})); // R12
                end
            end else begin
                nxt_time.min = 7'(bcd_inc({1'b0, time_ff.min})); // R24
            end
        end else begin
            nxt_time.sec = 7'(bcd_inc({1'b0, time_ff.sec})); // R13
        end
        if (day_carry) begin
            nxt_time.day_of_week_value = (time_ff.day_of_week_value == 3'h7) ? 3'h1 : time_ff.day_of_week_value + 3'h1; // R09
            // >= so a date loaded past the month end still rolls over
            if (time_ff.date >= date_max) begin
                nxt_time.date = 6'h01; // R07
                mth_carry = 1'b1;
            end else begin
                nxt_time.date = 6'(bcd_inc({2'h0, time_ff.date}));
            end
        end
        if (mth_carry) begin
            if (time_ff.mth == 5'h12) begin
                nxt_time.mth  = 5'h01; // R10
                nxt_time.year = (time_ff.year == 8'h99) ? 8'h00 : bcd_inc(time_ff.year); // R11
            end else begin
                nxt_time.mth = 5'(bcd_inc({3'h0, time_ff.mth}));
            end
        end
    end

    // host writes win over a tick in the same cycle; the host is expected to
    // stop the clock before loading, so a lost tick there is harmless
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            time_ff.sec   <= `RTK_RST_SEC; // R19
            time_ff.min   <= `RTK_RST_MIN;
            time_ff.hour  <= `RTK_RST_HOUR;
            time_ff.day_of_week_value <= `RTK_RST_DAY_OF_WEEK_VALUE;
            time_ff.date  <= `RTK_RST_DATE;
            time_ff.mth   <= `RTK_RST_MTH;
            time_ff.year  <= `RTK_RST_YEAR;
        end else if (ce) begin
            if (wr_en) begin
                case (reg_req.addr)
                    `RTK_ADDR_SEC:   time_ff.sec   <= reg_req.wdata[6:0]; // R19
                    `RTK_ADDR_MIN:   time_ff.min   <= reg_req.wdata[6:0]; // R20
                    `RTK_ADDR_HOUR:  time_ff.hour  <= reg_req.wdata[5:0];
                    `RTK_ADDR_DAY_OF_WEEK_VALUE: time_ff.day_of_week_value <= reg_req.wdata[2:0];
                    `RTK_ADDR_DATE:  time_ff.date  <= reg_req.wdata[5:0];
                    `RTK_ADDR_MTH:   time_ff.mth   <= reg_req.wdata[4:0];
                    `RTK_ADDR_YEAR:  time_ff.year  <= reg_req.wdata;
                    default:         time_ff       <= time_ff;
                endcase
            end else if (sec_tick) begin
                time_ff <= nxt_time; // R04
            end
        end
    end

    // ---------------- control bits ----------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            start_ff   <= 1'b0;
            hr_fmt_ff  <= 1'b0;
            vbat_en_ff <= 1'b0;
            ctrl_ff    <= `RTK_RST_CTRL;
        end else if (wr_en) begin
            case (reg_req.addr)
                `RTK_ADDR_SEC:   start_ff   <= reg_req.wdata[`RTK_BIT_START]; // R03
                `RTK_ADDR_HOUR:  hr_fmt_ff  <= reg_req.wdata[`RTK_BIT_HR_FMT]; // R12
                `RTK_ADDR_DAY_OF_WEEK_VALUE: vbat_en_ff <= reg_req.wdata[`RTK_BIT_VBAT_EN];
                `RTK_ADDR_CTRL:  ctrl_ff    <= reg_req.wdata;
                default:         start_ff   <= start_ff;
            endcase
        end
    end

    // ---------------- register images ----------------
    // power-loss flag has no source in this core and always reads zero
    always_comb begin
        live_bytes = '0;
        live_bytes[`RTK_ADDR_SEC]  = {start_ff, time_ff.sec}; // R19
        live_bytes[`RTK_ADDR_MIN]  = {1'b0, time_ff.min}; // R20
        live_bytes[`RTK_ADDR_HOUR] = {1'b0, hr_fmt_ff, time_ff.hour}; // R22
        live_bytes[`RTK_ADDR_DAY_OF_WEEK_VALUE] = {2'h0, osc_running_ff, 1'b0, vbat_en_ff, time_ff.day_of_week_value}; // R21
        live_bytes[`RTK_ADDR_DATE] = {2'h0, time_ff.date};
        live_bytes[`RTK_ADDR_MTH]  = {2'h0, leap, time_ff.mth}; // R05
        live_bytes[`RTK_ADDR_YEAR] = time_ff.year;
        live_bytes[`RTK_ADDR_CTRL] = ctrl_ff;
    end

    // ---------------- buffered reads ----------------
    assign ptr_inc   = rd_ptr_ff + 5'h1;
    assign rd_en     = reg_req.rd_start || reg_req.rd_next;
    assign rd_addr   = reg_req.rd_start ? reg_req.addr : ptr_inc;
    // a wrap reload gives every pass of a long burst one coherent snapshot
    assign snap_load = reg_req.rd_start || (reg_req.rd_next && ptr_inc == 5'h00); // R14 R15

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rd_valid_ff <= 1'b0;
        end else if (ce) begin
            rd_valid_ff <= rd_en; // R14
        end
    end

    // the pointer remembers the last byte served so rd_next needs no address
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rd_ptr_ff <= 5'h00;
        end else if (ce && rd_en) begin
            rd_ptr_ff <= rd_addr; // R15
        end
    end

    // one snapshot serves each pass of a sequential read, so digits cannot tear
    rtk_snap_buf u_snap (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .load      (snap_load), // R14
        .load_data (live_bytes),
        .rd_en     (rd_en),
        .raddr     (rd_addr),
        .rdata_ff  (rd_data)
    );

endmodule : rtk_core
`default_nettype wire

// ===== verilog/rtk_map.svh
// register offsets, field positions, reset values and timing counts of the timekeeping core
// assumes it is included by bare name from verilog/ sources
`ifndef RTK_MAP_SVH
`define RTK_MAP_SVH

`define RTK_ADDR_SEC        5'h00
`define RTK_ADDR_MIN        5'h01
`define RTK_ADDR_HOUR       5'h02
`define RTK_ADDR_DAY_OF_WEEK_VALUE      5'h03
`define RTK_ADDR_DATE       5'h04
`define RTK_ADDR_MTH        5'h05
`define RTK_ADDR_YEAR       5'h06
`define RTK_ADDR_CTRL       5'h07
`define RTK_ADDR_LAST       5'h1f
`define RTK_SNAP_DEPTH      8

`define RTK_BIT_START       7
`define RTK_BIT_HR_FMT      6
`define RTK_BIT_MERIDIEM    5
`define RTK_BIT_OSC_RUN     5
`define RTK_BIT_PWR_LOSS    4
`define RTK_BIT_VBAT_EN     3
`define RTK_BIT_LEAP        5
`define RTK_BIT_EXT_CLK     3

`define RTK_RST_SEC         7'h00
`define RTK_RST_MIN         7'h00
`define RTK_RST_HOUR        6'h00
`define RTK_RST_DAY_OF_WEEK_VALUE       3'h1
`define RTK_RST_DATE        6'h01
`define RTK_RST_MTH         5'h01
`define RTK_RST_YEAR        8'h00
`define RTK_RST_CTRL        8'h00

`define RTK_RUN_EDGES       6'h20
`define RTK_PRESCALE_LAST   15'h7fff
`define RTK_CLK_MHZ         50
`define RTK_OSF_TIMEOUT_US  1000

`endif

// ===== verilog/rtk_pkg.sv
// types shared by the timekeeping core and its snapshot buffer
// assumes rtk_map.svh supplies the numeric constants
package rtk_pkg;

    typedef struct packed {
        logic [6:0] sec;
        logic [6:0] min;
        logic [5:0] hour;
        logic [2:0] day_of_week_value;
        logic [5:0] date;
        logic [4:0] mth;
        logic [7:0] year;
    } rtk_time_t;

    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd_start;
        logic       rd_next;
    } rtk_req_t;

    typedef logic [7:0] rtk_byte_t;

endpackage : rtk_pkg

// ===== verilog/rtk_snap_buf.sv
// snapshot buffer holding the timekeeping bytes the host reads
// assumes load and read come from the same clock domain as the core
`timescale 1ns/10ps
`default_nettype none
`include "rtk_map.svh"

module rtk_snap_buf
    import rtk_pkg::*;
(
    input  wire logic                               clock,
    input  wire logic                               sys_rst,
    input  wire logic                               ce,
    input  wire logic                               load,
    input  wire rtk_byte_t [`RTK_SNAP_DEPTH-1:0]    load_data,
    input  wire logic                               rd_en,
    input  wire logic [4:0]                         raddr,
    output logic [7:0]                              rdata_ff
);

    // unpacked so each entry's process owns a variable of its own
    rtk_byte_t                       mem_ff [`RTK_SNAP_DEPTH];
    rtk_byte_t                       nxt_rdata;

    genvar gi;
    generate
        for (gi = 0; gi < `RTK_SNAP_DEPTH; gi++) begin : g_entry
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    mem_ff[gi] <= 8'h00;
                end else if (ce && load) begin
                    mem_ff[gi] <= load_data[gi];
                end
            end
        end
    endgenerate

    // a read in the loading cycle sees the fresh copy, not the stale one
    always_comb begin
        nxt_rdata = 8'h00;
        if (raddr < 5'(`RTK_SNAP_DEPTH)) begin
            nxt_rdata = load ? load_data[raddr[2:0]] : mem_ff[raddr[2:0]];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= 8'h00;
        end else if (ce && rd_en) begin
            rdata_ff <= nxt_rdata;
        end
    end

endmodule : rtk_snap_buf
`default_nettype wire
